// File: logic/rss_reset_supply.sv
// reset sequencer with supply-warning monitor
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "rss_defs.svh"
module rss_reset_supply (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic reset_pin_in,
  output logic reset_pin_out,
  output logic reset_pin_oe,
  input wire logic lvd_low,
  input wire logic avd_low,
  input wire logic wdg_underflow,
  input wire logic halt_mode,
  input wire logic wait_mode,
  input wire logic irq_ack,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic cpu_reset,
  output logic vector_fetch,
  output logic [15:0] vector_addr,
  output logic osc_enable,
  output logic [2:0] clock_source_selector,
  output logic supply_warning_irq,
  output logic wait_wakeup
);

  // three-stage synchronisers for asynchronous inputs
  logic [2:0] pin_sync_r;
  logic [2:0] pin_sync_nxt;
  logic [2:0] lvd_sync_r;
  logic [2:0] lvd_sync_nxt;
  logic [2:0] avd_sync_r;
  logic [2:0] avd_sync_nxt;
  logic pin_low_r;
  logic pin_low_nxt;
  logic lvd_f_r;
  logic lvd_f_nxt;
  logic avd_f_r;
  logic avd_f_nxt;

  // sequencer state
  rss_pkg::rss_phase_type phase_r;
  rss_pkg::rss_phase_type phase_nxt;
  logic [12:0] count_r;
  logic [12:0] count_nxt;
  logic [12:0] wdg_cnt_r;
  logic [12:0] wdg_cnt_nxt;

  // registers
  logic [7:0] opt_r;
  logic [7:0] opt_nxt;
  logic irq_en_r;
  logic irq_en_nxt;
  logic warn_r;
  logic warn_nxt;
  logic lvr_r;
  logic lvr_nxt;
  logic wdr_r;
  logic wdr_nxt;
  logic pend_r;
  logic pend_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  logic lvd_en;
  logic lvd_cause;
  logic any_cause;
  logic [12:0] delay_len;

  // the filtered level follows only when stages two and three agree
  function automatic logic filt(input logic [2:0] s, input logic prev);
    filt = (s[1] == s[2]) ? s[2] : prev;
  endfunction

  // one count step down; the phase and watchdog counters share it
  function automatic logic [12:0] dec13(input logic [12:0] v);
    dec13 = v - 13'h0001;
  endfunction

  // both counters end their span at zero
  function automatic logic is_zero(input logic [12:0] v);
    is_zero = (v == 13'h0000);
  endfunction

  // async pin detect
  // the low pin forces reset combinationally, so a halted clock cannot hide it
  // a pulse too short for the filter holds reset only while it lasts
  assign cpu_reset = (phase_r != rss_pkg::RSS_RUN) || !reset_pin_in;

  assign lvd_en = opt_r[`RSS_OPT_LVD_EN];
  assign lvd_cause = lvd_en && lvd_f_r;
  assign any_cause = pin_low_r || lvd_cause || wdg_underflow;
  assign delay_len = opt_r[`RSS_OPT_LONG_DELAY] ? `RSS_DELAY_LONG : `RSS_DELAY_SHORT;

  // synchroniser next values
  always_comb begin
    pin_sync_nxt = {pin_sync_r[1:0], !reset_pin_in};
    lvd_sync_nxt = {lvd_sync_r[1:0], lvd_low};
    avd_sync_nxt = {avd_sync_r[1:0], avd_low};
    pin_low_nxt = filt(pin_sync_r, pin_low_r);
    lvd_f_nxt = filt(lvd_sync_r, lvd_f_r);
    avd_f_nxt = filt(avd_sync_r, avd_f_r);
    // flush chain while driving
    // our own pull-down must not read back as an outside request; an outside pull
    // during the delay is invisible and only counts once the device lets go
    if (reset_pin_oe) begin
      pin_sync_nxt = 3'h0;
      pin_low_nxt = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      pin_sync_r <= 3'h0;
      lvd_sync_r <= 3'h0;
      avd_sync_r <= 3'h0;
      pin_low_r <= 1'b0;
      lvd_f_r <= 1'b0;
      avd_f_r <= 1'b0;
    end else begin
      pin_sync_r <= pin_sync_nxt;
      lvd_sync_r <= lvd_sync_nxt;
      avd_sync_r <= avd_sync_nxt;
      pin_low_r <= pin_low_nxt;
      lvd_f_r <= lvd_f_nxt;
      avd_f_r <= avd_f_nxt;
    end
  end

  // sequencer next state
  always_comb begin
    phase_nxt = phase_r;
    count_nxt = count_r;
    wdg_cnt_nxt = wdg_cnt_r;
    if (wdg_underflow) begin
      wdg_cnt_nxt = `RSS_WDG_PULSE_CYCLES;
    end else if (!is_zero(wdg_cnt_r)) begin
      wdg_cnt_nxt = dec13(wdg_cnt_r);
    end
    // every restart reloads the full delay, so a late cause never shortens it
    // restart on new cause
    if (any_cause || !is_zero(wdg_cnt_r)) begin
      phase_nxt = rss_pkg::RSS_ACTIVE;
      count_nxt = delay_len;
    end else begin
      case (phase_r)
        rss_pkg::RSS_ACTIVE: begin
          phase_nxt = rss_pkg::RSS_DELAY;
          count_nxt = dec13(delay_len);
        end
        rss_pkg::RSS_DELAY: begin
          if (is_zero(count_r)) begin
            phase_nxt = rss_pkg::RSS_FETCH;
            count_nxt = dec13({11'h000, `RSS_FETCH_CYCLES});
          end else begin
            count_nxt = dec13(count_r);
          end
        end
        rss_pkg::RSS_FETCH: begin
          if (is_zero(count_r)) begin
            phase_nxt = rss_pkg::RSS_RUN;
          end else begin
            count_nxt = dec13(count_r);
          end
        end
        rss_pkg::RSS_RUN: begin
          phase_nxt = rss_pkg::RSS_RUN;
        end
        default: begin
          phase_nxt = rss_pkg::RSS_ACTIVE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      phase_r <= rss_pkg::RSS_ACTIVE;
      count_r <= `RSS_DELAY_SHORT;
      wdg_cnt_r <= 13'h0000;
    end else begin
      phase_r <= phase_nxt;
      count_r <= count_nxt;
      wdg_cnt_r <= wdg_cnt_nxt;
    end
  end

  assign reset_pin_oe = (phase_r == rss_pkg::RSS_ACTIVE) || (phase_r == rss_pkg::RSS_DELAY)
    || lvd_cause || !is_zero(wdg_cnt_r);
  assign reset_pin_out = 1'b0;

  assign vector_fetch = (phase_r == rss_pkg::RSS_FETCH);
  // after the fetch the address idles at the low vector byte
  assign vector_addr = is_zero(count_r) ? `RSS_VECTOR_LO_ADDR : `RSS_VECTOR_HI_ADDR;

  assign osc_enable = 1'b1;
  assign clock_source_selector = opt_r[`RSS_OPT_CLK_MSB:`RSS_OPT_CLK_LSB];

  // register and supply-warning next values
  always_comb begin
    opt_nxt = opt_r;
    irq_en_nxt = irq_en_r;
    warn_nxt = warn_r;
    lvr_nxt = lvr_r;
    wdr_nxt = wdr_r;
    pend_nxt = pend_r;
    rdata_nxt = 8'h00;
    // the option register stays writable in halt; the control/status register and the pending request freeze
    if (reg_wr && reg_addr == `RSS_OFS_OPT) begin
      opt_nxt = reg_wdata;
    end
    if (!halt_mode) begin
      warn_nxt = lvd_en && avd_f_r;
      if (irq_ack) begin
        pend_nxt = 1'b0;
      end
      if (reg_wr && reg_addr == `RSS_OFS_CSR) begin
        irq_en_nxt = reg_wdata[`RSS_CSR_IRQ_EN];
        if (!reg_wdata[`RSS_CSR_LVR]) begin
          lvr_nxt = 1'b0;
        end
        if (!reg_wdata[`RSS_CSR_WDR]) begin
          wdr_nxt = 1'b0;
        end
        if (reg_wdata[`RSS_CSR_IRQ_EN] && !irq_en_r && warn_r && lvd_en) begin
          pend_nxt = 1'b1;
        end
      end
      // toggles before run are dropped: the supply is still settling then
      // toggle raises request
      if (irq_en_r && lvd_en && (warn_nxt != warn_r) && phase_r == rss_pkg::RSS_RUN) begin
        pend_nxt = 1'b1;
      end
      // set wins over the software clear
      if (wdg_underflow) begin
        wdr_nxt = 1'b1;
      end
      if (lvd_cause) begin
        lvr_nxt = 1'b1;
        wdr_nxt = 1'b0;
      end
    end
    // read data stands one cycle, then falls back to zero
    if (reg_rd) begin
      case (reg_addr)
        `RSS_OFS_CSR: begin
          rdata_nxt = {1'b0, irq_en_r, warn_r, lvr_r, 3'h0, wdr_r};
        end
        `RSS_OFS_OPT: begin
          rdata_nxt = opt_r;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // cause flags: set by their reset causes, cleared by zero writes or power-on reset; lvd also clears the watchdog flag
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      opt_r <= `RSS_OPT_RESET;
      irq_en_r <= 1'b0;
      warn_r <= 1'b0;
      pend_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      opt_r <= opt_nxt;
      irq_en_r <= irq_en_nxt;
      warn_r <= warn_nxt;
      pend_r <= pend_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      lvr_r <= 1'b0;
      wdr_r <= 1'b0;
    end else begin
      lvr_r <= lvr_nxt;
      wdr_r <= wdr_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign supply_warning_irq = pend_r;
  assign wait_wakeup = pend_r && wait_mode;

endmodule // rss_reset_supply

// File: shared/rss_defs.svh
// constants for the reset sequencer and supply monitor
`ifndef RSS_DEFS_SVH
`define RSS_DEFS_SVH

// stabilisation delay lengths in cpu clocks
`define RSS_DELAY_SHORT 13'h0100
`define RSS_DELAY_LONG 13'h1000
// vector fetch length in cpu clocks
`define RSS_FETCH_CYCLES 2'h2
// fixed reset vector addresses
`define RSS_VECTOR_HI_ADDR 16'hfffe
`define RSS_VECTOR_LO_ADDR 16'hffff
// least watchdog output pulse, in cpu clocks
`define RSS_WDG_PULSE_CYCLES 13'h0010

// register offsets
`define RSS_OFS_CSR 4'h0
`define RSS_OFS_OPT 4'h1

// control/status register field positions
`define RSS_CSR_IRQ_EN 6
`define RSS_CSR_WARN 5
`define RSS_CSR_LVR 4
`define RSS_CSR_WDR 0
`define RSS_CSR_RESET 8'h00

// option register field positions
`define RSS_OPT_LONG_DELAY 0
`define RSS_OPT_LVD_EN 1
`define RSS_OPT_CLK_LSB 2
`define RSS_OPT_CLK_MSB 4
`define RSS_OPT_RESET 8'h00

`endif

// File: shared/rss_pkg.sv
// types for the reset sequencer and supply monitor
package rss_pkg;

  typedef enum logic [1:0] {
    RSS_ACTIVE = 2'b00,
    RSS_DELAY = 2'b01,
    RSS_FETCH = 2'b10,
    RSS_RUN = 2'b11
  } rss_phase_type;

  // clock source: external clock or one of five resonator ranges
  typedef enum logic [2:0] {
    RSS_CLK_EXT = 3'b000,
    RSS_CLK_RES0 = 3'b001,
    RSS_CLK_RES1 = 3'b010,
    RSS_CLK_RES2 = 3'b011,
    RSS_CLK_RES3 = 3'b100,
    RSS_CLK_RES4 = 3'b101
  } rss_clk_src_type;

endpackage

// File: testbench/rss_ext_reset.sv
// partner model: external reset circuit on the shared reset line
`timescale 1ns/1ns
module rss_ext_reset (
  input wire logic pull_low,
  input wire logic dev_oe,
  output logic pin_level
);
  // open drain line
  // either party pulls low; otherwise the weak pull-up wins
  assign pin_level = !(pull_low || dev_oe);
endmodule // rss_ext_reset

// File: testbench/rss_reset_supply_monitor.sv
// assertion checker for the reset sequencer and supply monitor
`timescale 1ns/1ns
`include "rss_defs.svh"
module rss_reset_supply_monitor (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic reset_pin_in,
  input wire logic reset_pin_out,
  input wire logic reset_pin_oe,
  input wire logic lvd_low,
  input wire logic wdg_underflow,
  input wire logic wait_mode,
  input wire logic irq_ack,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic cpu_reset,
  input wire logic vector_fetch,
  input wire logic [15:0] vector_addr,
  input wire logic osc_enable,
  input wire logic supply_warning_irq,
  input wire logic wait_wakeup
);
  logic lvd_en_r;
  logic lvd_en_nxt;
  // shadow of the detector option bit, kept from option writes
  always_comb begin
    lvd_en_nxt = lvd_en_r;
    if (!reset_n) begin
      lvd_en_nxt = 1'b0;
    end else if (reg_wr && reg_addr == `RSS_OFS_OPT) begin
      lvd_en_nxt = reg_wdata[`RSS_OPT_LVD_EN];
    end
  end
  always_ff @(posedge ref_clk) begin
    lvd_en_r <= lvd_en_nxt;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  sequence s_fetch;
    vector_addr == 16'hfffe ##1 vector_fetch && vector_addr == 16'hffff ##1 !vector_fetch;
  endsequence
  property p_fetch;
    $rose(vector_fetch) |-> $past(reset_pin_oe) && cpu_reset ##0 s_fetch;
  endproperty
  a_fetch: assert property (p_fetch) else $error("vector fetch out of order");
  property p_osc;
    osc_enable;
  endproperty
  a_osc: assert property (p_osc) else $error("oscillator stopped");
  property p_odrain;
    !reset_pin_out;
  endproperty
  a_odrain: assert property (p_odrain) else $error("pin driven high");
  property p_pin;
    !reset_pin_in |-> cpu_reset;
  endproperty
  a_pin: assert property (p_pin) else $error("low pin not in reset");
  // the first cycle may still be the load cycle, so the check starts one later
  property p_wdg;
    wdg_underflow |=> ##1 reset_pin_oe [*8] ##1 reset_pin_oe [*7];
  endproperty
  a_wdg: assert property (p_wdg) else $error("watchdog pulse too short");
  property p_lvd;
    (lvd_en_r && lvd_low) [*6] |-> reset_pin_oe && cpu_reset;
  endproperty
  a_lvd: assert property (p_lvd) else $error("low supply not held in reset");
  property p_irq;
    $rose(supply_warning_irq) |-> lvd_en_r;
  endproperty
  a_irq: assert property (p_irq) else $error("warning irq without detector");
  property p_ack;
    irq_ack |=> !supply_warning_irq;
  endproperty
  a_ack: assert property (p_ack) else $error("pending irq not cleared");
  property p_wake;
    wait_wakeup == (supply_warning_irq && wait_mode);
  endproperty
  a_wake: assert property (p_wake) else $error("wait wakeup wrong");
endmodule // rss_reset_supply_monitor
bind rss_reset_supply rss_reset_supply_monitor rss_reset_supply_monitor_inst (.ref_clk,
  .reset_n, .reset_pin_in, .reset_pin_out, .reset_pin_oe, .lvd_low, .wdg_underflow,
  .wait_mode, .irq_ack, .reg_addr, .reg_wdata, .reg_wr, .cpu_reset, .vector_fetch,
  .vector_addr, .osc_enable, .supply_warning_irq, .wait_wakeup);

// File: testbench/tb_top.sv
// self-checking bench for the reset sequencer and supply monitor
`timescale 1ns/1ns
module tb_top;
  logic ref_clk, reset_n, reset_pin_in, reset_pin_out, reset_pin_oe, lvd_low, avd_low;
  logic wdg_underflow, halt_mode, wait_mode, irq_ack, reg_wr, reg_rd, cpu_reset;
  logic vector_fetch, osc_enable, supply_warning_irq, wait_wakeup, pull_low;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [15:0] vector_addr;
  logic [2:0] clock_source_selector;
  int bad_count, checks_done, n;
  rss_reset_supply rss_reset_supply_inst (.ref_clk, .reset_n, .reset_pin_in, .reset_pin_out,
    .reset_pin_oe, .lvd_low, .avd_low, .wdg_underflow, .halt_mode, .wait_mode, .irq_ack,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cpu_reset, .vector_fetch,
    .vector_addr, .osc_enable, .clock_source_selector, .supply_warning_irq, .wait_wakeup);
  rss_ext_reset rss_ext_reset_inst (.pull_low, .dev_oe(reset_pin_oe), .pin_level(reset_pin_in));
  // 25 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = !ref_clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tick(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // counts cycles up to the vector fetch, then expects the cpu running
  task seq(input int lo, input int hi);
    n = 0;
    while (vector_fetch !== 1'b1 && n < 5000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(n >= lo && n <= hi, 1);
    tick(3);
    #1 chk(cpu_reset, 0);
  endtask
  task pin(input int k);
    @(posedge ref_clk);
    pull_low <= 1'b1;
    #1 chk(cpu_reset, 1);
    tick(k);
    pull_low <= 1'b0;
  endtask
  task dog();
    @(posedge ref_clk);
    wdg_underflow <= 1'b1;
    @(posedge ref_clk);
    wdg_underflow <= 1'b0;
    tick(8);
    #1 chk(reset_pin_in, 0);
    seq(256, 300);
  endtask
  task ackp();
    @(posedge ref_clk);
    irq_ack <= 1'b1;
    @(posedge ref_clk);
    irq_ack <= 1'b0;
  endtask
  task end_of_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    {reset_n, pull_low, lvd_low, avd_low, wdg_underflow, halt_mode, wait_mode} = '0;
    {irq_ack, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    bad_count = 0;
    checks_done = 0;
    tick(16);
    reset_n <= 1'b1;
    seq(256, 268);
    rd(4'h0, 8'h00);
    rd(4'hf, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wr(4'h1, 8'(i << 2));
      #1 chk(clock_source_selector, 16'(i));
    end
    pin(10);
    // counted from the pin release, ten cycles into the pulse
    seq(246, 258);
    wr(4'h1, 8'h01);
    pin(10);
    seq(4086, 4098);
    wr(4'h1, 8'h00);
    pin(10);
    tick(100);
    // the device pulls the pin itself during the delay, but a watchdog cause still restarts it
    dog();
    dog();
    rd(4'h0, 8'h01);
    wr(4'h0, 8'h41);
    avd_low <= 1'b1;
    tick(8);
    #1 chk(supply_warning_irq, 0);
    rd(4'h0, 8'h41);
    @(posedge ref_clk);
    avd_low <= 1'b0;
    wr(4'h0, 8'h01);
    lvd_low <= 1'b1;
    tick(20);
    #1 chk(cpu_reset, 0);
    @(posedge ref_clk);
    lvd_low <= 1'b0;
    wr(4'h1, 8'h02);
    lvd_low <= 1'b1;
    tick(10);
    #1 chk({cpu_reset, reset_pin_in}, 2'b10);
    @(posedge ref_clk);
    lvd_low <= 1'b0;
    seq(256, 268);
    rd(4'h0, 8'h10);
    dog();
    rd(4'h0, 8'h11);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    @(posedge ref_clk);
    avd_low <= 1'b1;
    tick(8);
    #1 chk(supply_warning_irq, 0);
    rd(4'h0, 8'h20);
    wr(4'h0, 8'h40);
    tick(8);
    #1 chk(supply_warning_irq, 1);
    rd(4'h0, 8'h60);
    ackp();
    #1 chk(supply_warning_irq, 0);
    @(posedge ref_clk);
    avd_low <= 1'b0;
    wait_mode <= 1'b1;
    tick(8);
    #1 chk({supply_warning_irq, wait_wakeup}, 2'b11);
    @(posedge ref_clk);
    wait_mode <= 1'b0;
    ackp();
    halt_mode <= 1'b1;
    wr(4'h0, 8'h00);
    avd_low <= 1'b1;
    tick(8);
    rd(4'h0, 8'h40);
    @(posedge ref_clk);
    avd_low <= 1'b0;
    tick(4);
    halt_mode <= 1'b0;
    tick(8);
    end_of_test();
  end
  // hang guard, well beyond the expected run
  initial begin
    #1000000;
    bad_count++;
    end_of_test();
  end
endmodule // tb_top
